// ===== eia_consts.svh
// constants for the exception interrupt arbiter
`ifndef EIA_CONSTS_SVH
`define EIA_CONSTS_SVH
`define EIA_NSRC 24
`define EIA_REG_STAT_A 8'h00
`define EIA_REG_STAT_B 8'h04
`define EIA_REG_STAT_C 8'h08
`define EIA_REG_STAT_D 8'h0c
`define EIA_REG_CTRL 8'h10
`define EIA_REG_STATE 8'h14
`define EIA_REG_VECTOR 8'h18
`define EIA_VEC_RESET 16'hfffe
`define EIA_VEC_SWI 16'hfffc
`define EIA_VEC_PRIO1 16'hfffa
`define EIA_VEC_STEP 16'h0002
`define EIA_PRIO_RESET 5'h00
`define EIA_PRIO_NONE 5'h1f
`define EIA_CTRL_RESET 32'h0000_0002
`define EIA_RESP_OK 2'b00
`define EIA_RESP_SLVERR 2'b10
`define EIA_UNUSED_FLAGS 24'h0f_0000
`endif

// ===== eia_pkg.sv
// types shared by the exception interrupt arbiter files
package eia_pkg;
	typedef enum logic [2:0] {
		EIA_RUN = 3'b000,
		EIA_LATCHED = 3'b001,
		EIA_STACK = 3'b011,
		EIA_VECTOR = 3'b010,
		EIA_SERVICE = 3'b110
	} eia_state_e;
	typedef struct packed {
		logic instr_done;
		logic swi_exec;
		logic rti_exec;
		logic break_req;
		logic [15:0] pc;
	} eia_core_in_s;
	typedef struct packed {
		logic take;
		logic push_regs;
		logic pop_regs;
		logic set_mask;
		logic discard_prefetch;
		logic [4:0] prio;
		logic [15:0] vector;
		logic [15:0] stacked_pc;
	} eia_core_out_s;
endpackage

// ===== eia_prio_pick.sv
// fixed priority selector over request lines
`timescale 1ns/10ps
`include "eia_consts.svh"
module eia_prio_pick (
	input wire logic [`EIA_NSRC-1:0] req,
	output logic found,
	output logic [4:0] prio
);
	import eia_pkg::*;
	always_comb begin
		found = 1'b0;
		prio = `EIA_PRIO_NONE;
		for (int i = `EIA_NSRC - 1; i >= 0; i--) begin
			if (req[i]) begin
				found = 1'b1;
				prio = 5'(i + 1);
			end
		end
	end
endmodule // eia_prio_pick

// ===== eia_axil_slave.sv
// axi4-lite register slave: status, control and arbiter state
`timescale 1ns/10ps
`include "eia_consts.svh"
module eia_axil_slave (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [`EIA_NSRC-1:0] flags,
	input wire logic [31:0] state_word,
	input wire logic [31:0] vector_word,
	output logic [31:0] ctrl
);
	import eia_pkg::*;
	typedef struct packed {
		logic aw_got;
		logic [7:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [31:0] ctrl;
	} eia_bus_s;
	eia_bus_s q, next_q;
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == `EIA_REG_STAT_A) || (a == `EIA_REG_STAT_B) ||
			(a == `EIA_REG_STAT_C) || (a == `EIA_REG_STAT_D) ||
			(a == `EIA_REG_CTRL) || (a == `EIA_REG_STATE) || (a == `EIA_REG_VECTOR);
	endfunction
	always_comb begin
		next_q = q;
		if (awvalid && !q.aw_got) begin
			next_q.aw_got = 1'b1;
			next_q.aw_addr = awaddr;
		end
		if (wvalid && !q.w_got) begin
			next_q.w_got = 1'b1;
			next_q.w_data = wdata;
			next_q.w_strb = wstrb;
		end
		if (q.bvalid && bready)
			next_q.bvalid = 1'b0;
		if (q.aw_got && q.w_got && !q.bvalid) begin
			next_q.aw_got = 1'b0;
			next_q.w_got = 1'b0;
			next_q.bvalid = 1'b1;
			next_q.bresp = mapped(q.aw_addr) ? `EIA_RESP_OK : `EIA_RESP_SLVERR;
			// status registers ignore writes
			if (q.aw_addr == `EIA_REG_CTRL) begin
				for (int b = 0; b < 4; b++) begin
					if (q.w_strb[b])
						next_q.ctrl[b*8 +: 8] = q.w_data[b*8 +: 8];
				end
			end
		end
		if (q.rvalid && rready)
			next_q.rvalid = 1'b0;
		if (arvalid && !q.rvalid) begin
			next_q.rvalid = 1'b1;
			next_q.rresp = mapped(araddr) ? `EIA_RESP_OK : `EIA_RESP_SLVERR;
			// reads are side-effect free
			case (araddr)
				`EIA_REG_STAT_A: next_q.rdata = {24'h0, flags[5:0], 2'b00};
				`EIA_REG_STAT_B: next_q.rdata = {24'h0, flags[13:6]};
				`EIA_REG_STAT_C: next_q.rdata = {24'h0, flags[21:14]};
				`EIA_REG_STAT_D: next_q.rdata = {30'h0, flags[23:22]};
				`EIA_REG_CTRL: next_q.rdata = q.ctrl;
				`EIA_REG_STATE: next_q.rdata = state_word;
				`EIA_REG_VECTOR: next_q.rdata = vector_word;
				default: next_q.rdata = 32'h0;
			endcase
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.ctrl <= `EIA_CTRL_RESET;
		end else begin
			q <= next_q;
		end
	end
	assign awready = !q.aw_got;
	assign wready = !q.w_got;
	assign bvalid = q.bvalid;
	assign bresp = q.bresp;
	assign arready = !q.rvalid;
	assign rvalid = q.rvalid;
	assign rresp = q.rresp;
	assign rdata = q.rdata;
	assign ctrl = q.ctrl;
endmodule // eia_axil_slave

// ===== eia_arbiter.sv
// exception interrupt arbiter: latch, arbitrate and vector core requests
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "eia_consts.svh"
module eia_arbiter (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [`EIA_NSRC-1:0] src_req,
	input wire logic [`EIA_NSRC-1:0] src_enable,
	input wire logic global_mask,
	input wire eia_pkg::eia_core_in_s core_in,
	output eia_pkg::eia_core_out_s core_out,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);
	import eia_pkg::*;
	typedef struct packed {
		eia_state_e state;
		logic [`EIA_NSRC-1:0] flags;
		logic latched;
		logic latched_swi;
		logic [4:0] latched_prio;
		logic in_service;
		logic after_rti;
		eia_core_out_s out;
	} eia_arb_s;
	eia_arb_s q, next_q;
	logic [31:0] ctrl;
	logic [`EIA_NSRC-1:0] eligible;
	logic found;
	logic [4:0] win_prio;
	logic arb_enable;
	logic eff_mask;

	function automatic logic [15:0] vec_of(input logic software_interrupt_instr, input logic [4:0] prio);
		if (software_interrupt_instr)
			vec_of = `EIA_VEC_SWI;
		else
			vec_of = 16'(`EIA_VEC_PRIO1 - 16'(`EIA_VEC_STEP * 16'(prio - 5'd1)));
	endfunction

	// ctrl bit 0 forces the global mask, bit 1 enables arbitration
	assign arb_enable = ctrl[1];
	// a return reopens the boundary at once, so a pending request wins before the next opcode
	assign eff_mask = global_mask | ctrl[0] | (q.in_service & ~core_in.rti_exec);
	assign eligible = src_req & src_enable & ~`EIA_UNUSED_FLAGS & {`EIA_NSRC{~eff_mask}};

	eia_prio_pick u_pick (
		.req(eligible),
		.found(found),
		.prio(win_prio)
	);

	eia_axil_slave u_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.flags(q.flags),
		.state_word({24'h0, q.latched_prio, q.state}),
		.vector_word({16'h0, q.out.vector}),
		.ctrl(ctrl)
	);

	always_comb begin
		next_q = q;
		next_q.flags = src_req & ~`EIA_UNUSED_FLAGS;
		next_q.out.take = 1'b0;
		next_q.out.push_regs = 1'b0;
		next_q.out.pop_regs = 1'b0;
		next_q.out.set_mask = 1'b0;
		next_q.out.discard_prefetch = 1'b0;
		if (core_in.rti_exec) begin
			next_q.out.pop_regs = 1'b1;
			next_q.in_service = 1'b0;
			next_q.after_rti = 1'b1;
		end
		case (q.state)
			EIA_RUN: begin
				if (core_in.swi_exec || core_in.break_req) begin
					next_q.latched = 1'b1;
					next_q.latched_swi = 1'b1;
					next_q.latched_prio = `EIA_PRIO_RESET;
					next_q.state = EIA_LATCHED;
				end else if (core_in.instr_done && found && arb_enable) begin
					next_q.latched = 1'b1;
					next_q.latched_swi = 1'b0;
					next_q.latched_prio = win_prio;
					next_q.state = EIA_LATCHED;
				end else if (core_in.instr_done) begin
					next_q.after_rti = 1'b0;
				end
			end
			EIA_LATCHED: begin
				// held even if a higher source arrives; a set mask releases a hardware request
				if (!q.latched_swi && eff_mask) begin
					next_q.latched = 1'b0;
					next_q.state = EIA_RUN;
				end else begin
					next_q.state = EIA_STACK;
				end
			end
			EIA_STACK: begin
				// index high register is left to software
				next_q.out.push_regs = 1'b1;
				next_q.out.stacked_pc = q.latched_swi ? core_in.pc :
					16'(core_in.pc - 16'h0001);
				next_q.out.discard_prefetch = q.after_rti;
				next_q.state = EIA_VECTOR;
			end
			EIA_VECTOR: begin
				next_q.out.set_mask = 1'b1;
				next_q.out.take = 1'b1;
				next_q.out.prio = q.latched_prio;
				next_q.out.vector = vec_of(q.latched_swi, q.latched_prio);
				next_q.in_service = 1'b1;
				next_q.after_rti = 1'b0;
				next_q.state = EIA_SERVICE;
			end
			EIA_SERVICE: begin
				next_q.latched = 1'b0;
				next_q.state = EIA_RUN;
			end
			default: begin
				next_q.state = EIA_RUN;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.state <= EIA_RUN;
			q.out.prio <= `EIA_PRIO_RESET;
			q.out.vector <= `EIA_VEC_RESET;
		end else begin
			q <= next_q;
		end
	end
	assign core_out = q.out;
endmodule // eia_arbiter

// ===== eia_arbiter_checker.sv
// port assertions for the exception interrupt arbiter
`timescale 1ns/10ps
module eia_arbiter_checker import eia_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [23:0] src_req,
	input wire logic [23:0] src_enable,
	input wire logic global_mask,
	input wire eia_core_in_s core_in,
	input wire eia_core_out_s core_out
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [23:0] e1, e2, e3, e4;
	wire logic hw = core_out.take && core_out.prio != 5'h00;
	// eligible sources as seen at the boundary four edges back
	always_ff @(posedge aclk) begin
		e1 <= src_req & src_enable & {24{!global_mask}};
		e2 <= e1;
		e3 <= e2;
		e4 <= e3;
	end
	property p_vec;
		core_out.take |-> core_out.vector == 16'hfffc - {10'h000, core_out.prio, 1'b0};
	endproperty
	a_vec: assert property (p_vec) else $error("vector code wrong");
	property p_entry;
		core_out.push_regs |=> core_out.take && core_out.set_mask;
	endproperty
	a_entry: assert property (p_entry) else $error("entry order wrong");
	property p_swi;
		core_in.swi_exec |-> ##4 core_out.take && core_out.prio == 5'h00;
	endproperty
	a_swi: assert property (p_swi) else $error("software take missing");
	property p_spc;
		core_out.take |-> core_out.stacked_pc == $past(core_in.pc, 2) - {15'h0, hw};
	endproperty
	a_spc: assert property (p_spc) else $error("stacked pc wrong");
	property p_brk;
		core_in.break_req |-> ##4 core_out.take && core_out.vector == 16'hfffc;
	endproperty
	a_brk: assert property (p_brk) else $error("break vector wrong");
	property p_gate;
		hw |-> e4[core_out.prio - 5'h01];
	endproperty
	a_gate: assert property (p_gate) else $error("ineligible source taken");
	property p_prio;
		hw |-> (e4 & ((24'h1 << (core_out.prio - 5'h01)) - 24'h1)) == 24'h0;
	endproperty
	a_prio: assert property (p_prio) else $error("lower priority won");
	property p_bound;
		core_out.take |-> $past(core_in.instr_done || core_in.swi_exec || core_in.break_req, 4);
	endproperty
	a_bound: assert property (p_bound) else $error("take off boundary");
	property p_pop;
		core_in.rti_exec |-> ##[1:3] core_out.pop_regs;
	endproperty
	a_pop: assert property (p_pop) else $error("no pop on return");
	property p_disc;
		core_out.discard_prefetch |-> core_out.push_regs;
	endproperty
	a_disc: assert property (p_disc) else $error("discard off entry");
	c_hw: cover property (hw);
	c_sw: cover property (core_out.take && core_out.prio == 5'h00);
	c_disc: cover property (core_out.discard_prefetch);
endmodule // eia_arbiter_checker

// ===== eia_core_model.sv
// processor core stand-in facing the arbiter
`timescale 1ns/10ps
module eia_core_model import eia_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] go,
	input wire logic [15:0] pc,
	input wire eia_core_out_s core_out,
	output eia_core_in_s core_in,
	output logic in_isr
);
	// go is {break, return, software, instruction}; a return also ends an instruction
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			core_in <= '0;
			in_isr <= 1'b0;
		end else begin
			core_in <= {go[0] | go[2], go[1], go[2], go[3], pc};
			if (core_out.take) in_isr <= 1'b1;
			else if (core_out.pop_regs) in_isr <= 1'b0;
		end
	end
	// only pc and flags go to the stack, index high stays with software
endmodule // eia_core_model

// ===== exception_interrupt_arbiter_tb_top.sv
// self-checking bench for the exception interrupt arbiter
`timescale 1ns/10ps
`include "eia_consts.svh"
module exception_interrupt_arbiter_tb_top;
	import eia_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0, global_mask = 1'b1;
	logic [23:0] src_req = '0, src_enable = '1;
	logic [3:0] go = '0, wstrb = 4'hf;
	logic [15:0] pc = 16'h1234, t_vec, t_spc;
	eia_core_in_s core_in;
	eia_core_out_s core_out;
	logic in_isr, t_disc, awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr = '0, araddr = '0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = '0, rdata;
	logic [1:0] bresp, rresp;
	int n_mismatch = 0, cmp_count = 0, n_take = 0;
	always #10 aclk = ~aclk;
	eia_arbiter dut_u (.*);
	eia_core_model core_u (.*);
	always @(posedge aclk) begin
		if (core_out.take === 1'b1) begin
			t_vec <= core_out.vector;
			t_spc <= core_out.stacked_pc;
			n_take <= n_take + 1;
		end
		if (core_out.push_regs === 1'b1) t_disc <= core_out.discard_prefetch;
	end
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done;
		$display("mismatches %0d compares %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic hang;
		check("wait", 32'h0, 32'h1);
		test_done;
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int i;
		awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1; i = 0;
		do begin
			@(posedge aclk);
			i++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && i < 50);
		r = bresp;
		bready <= 1'b0;
		if (!bvalid) hang;
		// one idle edge so a following call never re-drives bready in this step
		@(posedge aclk);
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int i;
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1; i = 0;
		do begin
			@(posedge aclk);
			i++;
			if (arready) arvalid <= 1'b0;
		end while (!rvalid && i < 50);
		d = rdata; r = rresp; rready <= 1'b0;
		if (!rvalid) hang;
		@(posedge aclk);
	endtask
	task automatic pulse(input logic [3:0] g);
		go <= g;
		@(posedge aclk);
		go <= 4'h0;
	endtask
	task automatic wait_take(input int n0);
		int i;
		for (i = 0; i < 20 && n_take == n0; i++) @(posedge aclk);
		if (n_take == n0) hang;
	endtask
	task automatic t_regs;
		logic [31:0] d, exp;
		logic [1:0] r;
		logic [23:0] q;
		int i, k;
		for (k = 0; k < 2; k++) begin
			q = k ? 24'h905a3c : 24'h60a5c3;
			src_req <= q;
			exp = {6'h00, q[23:22], q[21:14], q[13:6], q[5:0], 2'b00};
			tick(3);
			axw(`EIA_REG_STAT_A, 32'hffffffff, r);
			check("wresp", r, `EIA_RESP_OK);
			for (i = 0; i < 8; i++) begin
				axr(8'(4 * (i % 4)), d, r);
				check("status", d, {24'h0, exp[8 * (i % 4) +: 8]});
			end
		end
		axr(8'h20, d, r);
		check("unmapped", {d[29:0], r}, 32'h2);
		axr(`EIA_REG_CTRL, d, r);
		check("ctrl", d, `EIA_CTRL_RESET);
		src_req <= '0;
	endtask
	task automatic t_mask;
		int n;
		logic [1:0] r;
		n = n_take; src_req <= 24'h2; tick(2); pulse(4'h1); tick(6);
		check("masked", n_take, n);
		global_mask <= 1'b0; src_enable <= 24'hfffffd; tick(2); pulse(4'h1); tick(6);
		check("disabled", n_take, n);
		src_enable <= '1;
		// forced mask in ctrl must hold off an enabled, unmasked source
		axw(`EIA_REG_CTRL, 32'h3, r);
		pulse(4'h1);
		tick(6);
		check("forced", n_take, n);
		axw(`EIA_REG_CTRL, `EIA_CTRL_RESET, r);
		check("ctrl_wr", r, `EIA_RESP_OK);
		src_req <= '0;
		tick(2);
	endtask
	task automatic t_prio;
		int n;
		n = n_take; src_req <= 24'h14; tick(2); pulse(4'h1); wait_take(n);
		check("vector", t_vec, 16'hfff6);
		check("hw_pc", t_spc, pc - 16'h1);
		check("in_isr", in_isr, 1'b1);
		// flag 1 arrives while flag 3 is in service and must wait
		src_req <= 24'h11; n = n_take; tick(2); pulse(4'h1); tick(6);
		check("held", n_take, n);
		pulse(4'h4); wait_take(n);
		check("vector2", t_vec, `EIA_VEC_PRIO1);
		check("discard", t_disc, 1'b1);
		src_req <= '0; pulse(4'h4); tick(4);
	endtask
	task automatic t_swi;
		int n;
		logic [31:0] d;
		logic [1:0] r;
		global_mask <= 1'b1; n = n_take; pulse(4'h2); wait_take(n);
		check("swi", t_vec, `EIA_VEC_SWI);
		check("sw_pc", t_spc, pc);
		pulse(4'h4); tick(3);
		n = n_take; pulse(4'h8); wait_take(n);
		check("break", t_vec, `EIA_VEC_SWI);
		axr(`EIA_REG_VECTOR, d, r);
		check("vec_reg", d, {16'h0, `EIA_VEC_SWI});
		pulse(4'h4); tick(3);
	endtask
	initial begin
		tick(6);
		aresetn <= 1'b1;
		tick(1);
		check("reset_vec", core_out.vector, `EIA_VEC_RESET);
		t_regs;
		t_mask;
		t_prio;
		t_swi;
		test_done;
	end
endmodule // exception_interrupt_arbiter_tb_top
bind eia_arbiter eia_arbiter_checker chk_u (.*);
